// [src/dci_map.svh]
`ifndef DCI_MAP_SVH
`define DCI_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define DCI_CTRL_OFS 8'h00
`define DCI_STATUS_OFS 8'h04
`define DCI_IRQ_STATUS_OFS 8'h08
`define DCI_IRQ_MASK_OFS 8'h0c
// ****************************************
// control fields and reset value
// ****************************************
`define DCI_CTRL_CONV_LSB 0
`define DCI_CTRL_CONV_MSB 2
`define DCI_CTRL_JOG_THERMAL_BIT 3
`define DCI_CTRL_STOP_FUNC_LSB 4
`define DCI_CTRL_STOP_FUNC_MSB 5
`define DCI_CTRL_SECOND_SET_BIT 6
`define DCI_CTRL_RESTART_PARAM_BIT 7
`define DCI_CTRL_RESET 8'h00
// ****************************************
// converter connection values
// ****************************************
`define DCI_CONV_STOP_ENABLE 3'h3
`define DCI_CONV_SECOND_ENABLE 3'h4
`define DCI_CONV_SECOND_POWER 3'h5
// ****************************************
// input positions
// ****************************************
`define DCI_IN_JOG 0
`define DCI_IN_SECOND 1
`define DCI_IN_STOP 2
`define DCI_IN_RESET 3
`define DCI_IN_CURRENT 4
`define DCI_IN_RESTART 5
`define DCI_IN_FORWARD 6
`define DCI_IN_REVERSE 7
`define DCI_IN_COUNT 8
// ****************************************
// interrupt event positions
// ****************************************
`define DCI_EV_THERMAL 0
`define DCI_EV_SHUTOFF 1
`define DCI_EV_CLEARED 2
`define DCI_EV_POWER_FAIL 3
`define DCI_EV_COUNT 4
// ****************************************
// timing
// ****************************************
`define DCI_CLK_PERIOD_NS 40
`define DCI_STOP_HOLD_NS 20000000
`define DCI_RESET_HOLD_NS 100000000
`define DCI_FILTER_NS 1000000
`define DCI_STOP_HOLD_CYC ((`DCI_STOP_HOLD_NS + `DCI_CLK_PERIOD_NS - 1) / `DCI_CLK_PERIOD_NS)
`define DCI_RESET_HOLD_CYC ((`DCI_RESET_HOLD_NS + `DCI_CLK_PERIOD_NS - 1) / `DCI_CLK_PERIOD_NS)
`define DCI_FILTER_CYC ((`DCI_FILTER_NS + `DCI_CLK_PERIOD_NS - 1) / `DCI_CLK_PERIOD_NS)
`endif

// [src/dci_pkg.sv]
package dci_pkg;
   typedef enum logic [1:0] {
      RST_IDLE = 2'h0,
      RST_HELD = 2'h1,
      RST_QUAL = 2'h3
   } dci_reset_state_type;
   typedef enum logic [1:0] {
      STOP_AS_SHUTOFF = 2'h0,
      STOP_AS_DC_BRAKE = 2'h1,
      STOP_AS_PANEL_LOCK = 2'h2
   } dci_stop_func_type;
endpackage

// [src/dci_decoder.sv]
`include "dci_map.svh"
// Contract
// - jog select on enables jog mode; forward or reverse start then runs jog.
// - jog input as thermal relay input stops output when relay operates.
// - second function select on picks second accel and decel time set; at converter setting 3 the code ignores the select.
// - with second settings configured, select also picks second boost and base freq.
// - converter setting 4 or 5 turns second select into enable or power fail input; the code makes it the enable input at both settings.
// - output stop held at least 20 ms shuts off the output.
// - output stop input may act as DC brake start or panel interlock.
// - converter setting 3 turns output stop into operation enable input.
// - fault reset held over 0.1 s then released clears protective trip.
// - current reference accepted only while current input select is on.
// - converter setting 3, 4 or 5 reassigns current select to enable or power fail; the code makes it the power fail input at all three.
// - restart select plus restart parameters allow auto restart; disallowed by default.
module dci_decoder #(
   parameter int STOP_CYC = `DCI_STOP_HOLD_CYC,
   parameter int RESET_CYC = `DCI_RESET_HOLD_CYC,
   parameter int FILTER_CYC = `DCI_FILTER_CYC,
   parameter int CNT_W = 24
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_CE,
   input wire logic I_JOG_OR_THERMAL_INPUT,
   input wire logic I_SECOND_FUNCTION_SELECT,
   input wire logic I_OUTPUT_STOP_INPUT,
   input wire logic I_FAULT_RESET_INPUT,
   input wire logic I_CURRENT_INPUT_SELECT,
   input wire logic I_RESTART_SELECT,
   input wire logic I_FORWARD_START_INPUT,
   input wire logic I_REVERSE_START_INPUT,
   input wire logic I_PROTECTIVE_TRIP,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [7:0] I_AWADDR,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [7:0] I_ARADDR,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_JOG_MODE,
   output logic O_JOG_FORWARD,
   output logic O_JOG_REVERSE,
   output logic O_SECOND_ACCEL_DECEL,
   output logic O_SECOND_BOOST_BASE,
   output logic O_OUTPUT_SHUTOFF,
   output logic O_DC_BRAKE_START,
   output logic O_PANEL_INTERLOCK,
   output logic O_OPERATION_ENABLE,
   output logic O_POWER_FAIL_DETECT,
   output logic O_CURRENT_REF_ACCEPT,
   output logic O_AUTO_RESTART_ENABLE,
   output logic O_FAULT_CLEAR,
   output logic O_IRQ
);
   localparam int N = `DCI_IN_COUNT;
   localparam int E = `DCI_EV_COUNT;
   localparam logic [CNT_W-1:0] STOP_LIM = CNT_W'(STOP_CYC);
   localparam logic [CNT_W-1:0] RESET_LIM = CNT_W'(RESET_CYC);
   localparam logic [CNT_W-1:0] FILT_LIM = CNT_W'(FILTER_CYC);

   // ****************************************
   // input synchronisers and debounce
   // ****************************************
   logic [N-1:0] raw;
   logic [N-1:0] sync1;
   logic [N-1:0] sync2;
   logic [N-1:0] filt;
   logic [N-1:0] next_filt;
   logic [CNT_W-1:0] fcnt [N];
   logic [CNT_W-1:0] next_fcnt [N];

   assign raw = {I_REVERSE_START_INPUT, I_FORWARD_START_INPUT, I_RESTART_SELECT,
                 I_CURRENT_INPUT_SELECT, I_FAULT_RESET_INPUT, I_OUTPUT_STOP_INPUT,
                 I_SECOND_FUNCTION_SELECT, I_JOG_OR_THERMAL_INPUT};

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_filt
         // a level only moves after it stood stable for the whole filter time
         always_comb begin
            next_filt[g] = filt[g];
            next_fcnt[g] = '0;
            if (sync2[g] != filt[g]) begin
               if (fcnt[g] >= FILT_LIM - CNT_W'(1)) begin
                  next_filt[g] = sync2[g];
               end else begin
                  next_fcnt[g] = fcnt[g] + CNT_W'(1);
               end
            end
         end
         always_ff @(posedge I_CLK) begin
            if (I_RST) begin
               fcnt[g] <= '0;
            end else if (I_CE) begin
               fcnt[g] <= next_fcnt[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         sync1 <= '0;
         sync2 <= '0;
         filt <= '0;
      end else if (I_CE) begin
         sync1 <= raw;
         sync2 <= sync1;
         filt <= next_filt;
      end
   end

   // ****************************************
   // register file and bus slave
   // ****************************************
   logic [7:0] ctrl;
   logic [E-1:0] irq_status;
   logic [E-1:0] irq_mask;
   logic [E-1:0] events;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic [7:0] next_ctrl;
   logic [E-1:0] next_irq_status;
   logic [E-1:0] next_irq_mask;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic wr_go;
   logic rd_go;
   logic [15:0] status_word;

   function automatic logic known(input logic [7:0] addr);
      return addr == `DCI_CTRL_OFS || addr == `DCI_STATUS_OFS ||
             addr == `DCI_IRQ_STATUS_OFS || addr == `DCI_IRQ_MASK_OFS;
   endfunction

   // address and data are taken together, so no half write is ever parked
   assign wr_go = I_AWVALID && I_WVALID && !bvalid;
   assign rd_go = I_ARVALID && !rvalid;
   assign O_AWREADY = wr_go && I_CE;
   assign O_WREADY = wr_go && I_CE;
   assign O_ARREADY = rd_go && I_CE;

   always_comb begin
      next_ctrl = ctrl;
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      next_bvalid = bvalid && !I_BREADY;
      next_bresp = bresp;
      next_rvalid = rvalid && !I_RREADY;
      next_rdata = rdata;
      next_rresp = rresp;
      if (wr_go) begin
         next_bvalid = 1'b1;
         next_bresp = known(I_AWADDR) ? 2'h0 : 2'h2;
         if (I_WSTRB[0] && I_AWADDR == `DCI_CTRL_OFS) begin
            next_ctrl = I_WDATA[7:0];
         end
         if (I_WSTRB[0] && I_AWADDR == `DCI_IRQ_MASK_OFS) begin
            next_irq_mask = I_WDATA[E-1:0];
         end
         if (I_WSTRB[0] && I_AWADDR == `DCI_IRQ_STATUS_OFS) begin
            next_irq_status = irq_status & ~I_WDATA[E-1:0];
         end
      end
      // a new event outranks a clear in the same cycle
      next_irq_status = next_irq_status | events;
      if (rd_go) begin
         next_rvalid = 1'b1;
         next_rresp = known(I_ARADDR) ? 2'h0 : 2'h2;
         unique case (I_ARADDR)
            `DCI_CTRL_OFS: next_rdata = {24'h0, ctrl};
            `DCI_STATUS_OFS: next_rdata = {16'h0, status_word};
            `DCI_IRQ_STATUS_OFS: next_rdata = {28'h0, irq_status};
            `DCI_IRQ_MASK_OFS: next_rdata = {28'h0, irq_mask};
            default: next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         ctrl <= `DCI_CTRL_RESET;
         irq_status <= '0;
         irq_mask <= '0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= 2'h0;
      end else if (I_CE) begin
         ctrl <= next_ctrl;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   assign O_BVALID = bvalid;
   assign O_BRESP = bresp;
   assign O_RVALID = rvalid;
   assign O_RDATA = rdata;
   assign O_RRESP = rresp;
   assign O_IRQ = |(irq_status & irq_mask);

   // ****************************************
   // hold timers and fault reset sequence
   // ****************************************
   logic [2:0] conv;
   dci_pkg::dci_stop_func_type stop_func;
   logic stop_normal;
   logic [CNT_W-1:0] stop_cnt;
   logic [CNT_W-1:0] next_stop_cnt;
   logic [CNT_W-1:0] clr_cnt;
   logic [CNT_W-1:0] next_clr_cnt;
   dci_pkg::dci_reset_state_type clr_state;
   dci_pkg::dci_reset_state_type next_clr_state;
   logic next_fault_clear;

   assign conv = ctrl[`DCI_CTRL_CONV_MSB:`DCI_CTRL_CONV_LSB];
   assign stop_func = dci_pkg::dci_stop_func_type'(
      ctrl[`DCI_CTRL_STOP_FUNC_MSB:`DCI_CTRL_STOP_FUNC_LSB]);
   assign stop_normal = conv != `DCI_CONV_STOP_ENABLE;

   always_comb begin
      next_stop_cnt = '0;
      if (filt[`DCI_IN_STOP]) begin
         next_stop_cnt = (stop_cnt >= STOP_LIM) ? stop_cnt : stop_cnt + CNT_W'(1);
      end
      next_clr_cnt = '0;
      next_clr_state = clr_state;
      next_fault_clear = 1'b0;
      unique case (clr_state)
         dci_pkg::RST_IDLE: begin
            if (filt[`DCI_IN_RESET]) begin
               next_clr_state = dci_pkg::RST_HELD;
            end
         end
         dci_pkg::RST_HELD: begin
            next_clr_cnt = clr_cnt + CNT_W'(1);
            if (!filt[`DCI_IN_RESET]) begin
               next_clr_state = dci_pkg::RST_IDLE;
            end else if (clr_cnt >= RESET_LIM) begin
               next_clr_state = dci_pkg::RST_QUAL;
            end
         end
         dci_pkg::RST_QUAL: begin
            // the clear fires on release, not while the contact is still held
            if (!filt[`DCI_IN_RESET]) begin
               next_clr_state = dci_pkg::RST_IDLE;
               next_fault_clear = I_PROTECTIVE_TRIP;
            end
         end
         default: next_clr_state = dci_pkg::RST_IDLE;
      endcase
   end

   // ****************************************
   // function decoding
   // ****************************************
   logic jog_mode;
   logic thermal;
   logic shutoff;
   logic power_fail;
   logic [12:0] dec;
   logic [12:0] next_dec;

   always_comb begin
      thermal = ctrl[`DCI_CTRL_JOG_THERMAL_BIT] && filt[`DCI_IN_JOG];
      jog_mode = !ctrl[`DCI_CTRL_JOG_THERMAL_BIT] && filt[`DCI_IN_JOG];
      shutoff = thermal || (stop_normal && stop_func == dci_pkg::STOP_AS_SHUTOFF &&
                            stop_cnt >= STOP_LIM);
      power_fail = 1'b0;
      next_dec = '0;
      next_dec[0] = jog_mode;
      next_dec[1] = jog_mode && filt[`DCI_IN_FORWARD] && !filt[`DCI_IN_REVERSE];
      next_dec[2] = jog_mode && filt[`DCI_IN_REVERSE] && !filt[`DCI_IN_FORWARD];
      next_dec[5] = shutoff;
      next_dec[6] = stop_normal && stop_func == dci_pkg::STOP_AS_DC_BRAKE &&
                    filt[`DCI_IN_STOP];
      next_dec[7] = stop_normal && stop_func == dci_pkg::STOP_AS_PANEL_LOCK &&
                    filt[`DCI_IN_STOP];
      next_dec[11] = filt[`DCI_IN_RESTART] && ctrl[`DCI_CTRL_RESTART_PARAM_BIT];
      unique case (conv)
         `DCI_CONV_STOP_ENABLE: begin
            next_dec[8] = filt[`DCI_IN_STOP];
            power_fail = filt[`DCI_IN_CURRENT];
         end
         `DCI_CONV_SECOND_ENABLE, `DCI_CONV_SECOND_POWER: begin
            // converter links a single enable; the current input then reports supply loss
            next_dec[8] = filt[`DCI_IN_SECOND];
            power_fail = filt[`DCI_IN_CURRENT];
         end
         default: begin
            next_dec[3] = filt[`DCI_IN_SECOND];
            next_dec[4] = filt[`DCI_IN_SECOND] && ctrl[`DCI_CTRL_SECOND_SET_BIT];
            next_dec[10] = filt[`DCI_IN_CURRENT];
         end
      endcase
      next_dec[9] = power_fail;
      next_dec[12] = next_fault_clear;
      events = '0;
      events[`DCI_EV_THERMAL] = thermal && !(dec[5] && ctrl[`DCI_CTRL_JOG_THERMAL_BIT]);
      events[`DCI_EV_SHUTOFF] = next_dec[5] && !dec[5];
      events[`DCI_EV_CLEARED] = next_fault_clear;
      events[`DCI_EV_POWER_FAIL] = power_fail && !dec[9];
      events = I_CE ? events : '0;
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         stop_cnt <= '0;
         clr_cnt <= '0;
         clr_state <= dci_pkg::RST_IDLE;
         dec <= '0;
      end else if (I_CE) begin
         stop_cnt <= next_stop_cnt;
         clr_cnt <= next_clr_cnt;
         clr_state <= next_clr_state;
         dec <= next_dec;
      end
   end

   assign status_word = {dec[11:0], 4'h0} | {8'h0, filt};
   assign O_JOG_MODE = dec[0];
   assign O_JOG_FORWARD = dec[1];
   assign O_JOG_REVERSE = dec[2];
   assign O_SECOND_ACCEL_DECEL = dec[3];
   assign O_SECOND_BOOST_BASE = dec[4];
   assign O_OUTPUT_SHUTOFF = dec[5];
   assign O_DC_BRAKE_START = dec[6];
   assign O_PANEL_INTERLOCK = dec[7];
   assign O_OPERATION_ENABLE = dec[8];
   assign O_POWER_FAIL_DETECT = dec[9];
   assign O_CURRENT_REF_ACCEPT = dec[10];
   assign O_AUTO_RESTART_ENABLE = dec[11];
   assign O_FAULT_CLEAR = dec[12];
endmodule

// [dv/dci_contacts.sv]
// ****
// contact partner
// ****
module dci_contacts (
   input wire logic i_clk,
   input wire logic [7:0] i_cmd,
   output logic [7:0] o_contact = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // contacts move only just after an edge, so no bus race with the sync flops
   always @(posedge i_clk) begin
      o_contact <= i_cmd;
   end
endmodule

// [dv/dci_decoder_sva.sv]
// ****
// port checker
// ****
module dci_decoder_chk (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_CE,
   input wire logic I_SECOND_FUNCTION_SELECT,
   input wire logic I_AWVALID,
   input wire logic I_WVALID,
   input wire logic [7:0] I_AWADDR,
   input wire logic I_BREADY,
   input wire logic I_ARVALID,
   input wire logic I_RREADY,
   input wire logic O_AWREADY,
   input wire logic O_WREADY,
   input wire logic O_ARREADY,
   input wire logic O_BVALID,
   input wire logic [1:0] O_BRESP,
   input wire logic O_RVALID,
   input wire logic [31:0] O_RDATA,
   input wire logic O_JOG_MODE,
   input wire logic O_JOG_FORWARD,
   input wire logic O_JOG_REVERSE,
   input wire logic O_SECOND_ACCEL_DECEL,
   input wire logic O_FAULT_CLEAR
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   property p_bhold;
      O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped early");
   property p_rhold;
      O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped early");
   property p_wans;
      I_AWVALID && I_WVALID && !O_BVALID && I_CE |-> O_AWREADY && O_WREADY ##1 O_BVALID;
   endproperty
   a_wans: assert property (p_wans) else $error("write not answered");
   property p_rans;
      I_ARVALID && !O_RVALID && I_CE |-> O_ARREADY ##1 O_RVALID;
   endproperty
   a_rans: assert property (p_rans) else $error("read not answered");
   property p_unmap;
      I_AWVALID && I_WVALID && !O_BVALID && I_CE && I_AWADDR > 8'h0c |=> O_BRESP == 2'b10;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped write not refused");
   property p_jog;
      O_JOG_FORWARD |-> O_JOG_MODE && !O_JOG_REVERSE;
   endproperty
   a_jog: assert property (p_jog) else $error("jog direction conflict");
   // a rise must come from an input that was high both 5 and 6 cycles earlier, two samples of the filter window
   property p_filt;
      $rose(O_SECOND_ACCEL_DECEL) |-> $past(I_SECOND_FUNCTION_SELECT, 5)
         && $past(I_SECOND_FUNCTION_SELECT, 6);
   endproperty
   a_filt: assert property (p_filt) else $error("unfiltered second select");
   property p_clr;
      O_FAULT_CLEAR |=> !O_FAULT_CLEAR;
   endproperty
   a_clr: assert property (p_clr) else $error("fault clear not a pulse");
endmodule
bind dci_decoder dci_decoder_chk u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE),
   .I_SECOND_FUNCTION_SELECT(I_SECOND_FUNCTION_SELECT), .I_AWVALID(I_AWVALID),
   .I_WVALID(I_WVALID), .I_AWADDR(I_AWADDR), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
   .I_RREADY(I_RREADY), .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_ARREADY(O_ARREADY),
   .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
   .O_JOG_MODE(O_JOG_MODE), .O_JOG_FORWARD(O_JOG_FORWARD), .O_JOG_REVERSE(O_JOG_REVERSE),
   .O_SECOND_ACCEL_DECEL(O_SECOND_ACCEL_DECEL), .O_FAULT_CLEAR(O_FAULT_CLEAR));

// [dv/tb.sv]
`include "dci_map.svh"
// ****
// testbench
// ****
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int L = 14;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic trip = 1'b0;
   logic ce = 1'b1;
   logic [7:0] cmd = 8'h00;
   logic [7:0] ct;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awr, wr_r, bv, arr, rv;
   logic [1:0] br, rr;
   logic [31:0] rd;
   logic [13:0] d;
   int mismatches = 0, n_tests = 0;
   always #20 clk = ~clk;
   dci_contacts u_sw (.i_clk(clk), .i_cmd(cmd), .o_contact(ct));
   // short counts keep the run brief; waits below are derived from them
   dci_decoder #(.STOP_CYC(20), .RESET_CYC(50), .FILTER_CYC(4)) DUT (.I_CLK(clk),
      .I_RST(rst), .I_CE(ce), .I_JOG_OR_THERMAL_INPUT(ct[0]),
      .I_SECOND_FUNCTION_SELECT(ct[1]), .I_OUTPUT_STOP_INPUT(ct[2]),
      .I_FAULT_RESET_INPUT(ct[3]), .I_CURRENT_INPUT_SELECT(ct[4]), .I_RESTART_SELECT(ct[5]),
      .I_FORWARD_START_INPUT(ct[6]), .I_REVERSE_START_INPUT(ct[7]), .I_PROTECTIVE_TRIP(trip),
      .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr_r),
      .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br),
      .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry),
      .O_RDATA(rd), .O_RRESP(rr), .O_JOG_MODE(d[0]), .O_JOG_FORWARD(d[1]),
      .O_JOG_REVERSE(d[2]), .O_SECOND_ACCEL_DECEL(d[3]), .O_SECOND_BOOST_BASE(d[4]),
      .O_OUTPUT_SHUTOFF(d[5]), .O_DC_BRAKE_START(d[6]), .O_PANEL_INTERLOCK(d[7]),
      .O_OPERATION_ENABLE(d[8]), .O_POWER_FAIL_DETECT(d[9]), .O_CURRENT_REF_ACCEPT(d[10]),
      .O_AUTO_RESTART_ENABLE(d[11]), .O_FAULT_CLEAR(d[12]), .O_IRQ(d[13]));
   task tally_and_finish;
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   // ends between edges so that every look at the outputs sees settled values
   task tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task sw(input int i, input logic v, input int n);
      @(posedge clk);
      cmd[i] <= v;
      tick(n);
   endtask
   // ready comes one cycle late so the answer must stand while it waits
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'b00);
      @(posedge clk);
      {awv, wv, awa, wd} <= {2'h3, a, v};
      @(negedge clk);
      while (!(awr && wr_r)) @(negedge clk);
      @(posedge clk);
      {awv, wv} <= 2'h0;
      @(negedge clk);
      while (!bv) @(negedge clk);
      @(posedge clk);
      bry <= 1'b1;
      @(negedge clk);
      chk(br === er, "write response");
      @(posedge clk);
      bry <= 1'b0;
      @(negedge clk);
   endtask
   task rdx(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er = 2'b00);
      @(posedge clk);
      {arv, ara} <= {1'b1, a};
      @(negedge clk);
      while (!arr) @(negedge clk);
      @(posedge clk);
      arv <= 1'b0;
      @(negedge clk);
      while (!rv) @(negedge clk);
      @(posedge clk);
      rry <= 1'b1;
      @(negedge clk);
      chk(rr === er && rd === ev, "read data");
      @(posedge clk);
      rry <= 1'b0;
      @(negedge clk);
   endtask
   task pulses(input int ex);
      int n;
      n = 0;
      repeat (2 * L) begin @(negedge clk); if (d[12] === 1'b1) n++; end
      chk(n == ex, "fault clear count");
   endtask
   initial begin
      tick(4);
      rst <= 1'b0;
      rdx(`DCI_CTRL_OFS, 32'h0);
      rdx(8'h40, 32'h0, 2'b10);
      wr(8'h40, 32'hff, 2'b10);
      sw(0, 1'b1, 0);
      sw(6, 1'b1, L);
      chk(d[0] && d[1] && !d[2], "jog forward");
      sw(7, 1'b1, L);
      chk(!d[1] && !d[2], "jog both starts");
      sw(6, 1'b0, L);
      chk(d[0] && d[2] && !d[1], "jog reverse");
      sw(7, 1'b0, 0);
      sw(0, 1'b0, L);
      wr(`DCI_CTRL_OFS, 32'h08);
      sw(0, 1'b1, L);
      chk(d[5] && !d[0] && !d[13], "thermal trip masked");
      wr(`DCI_IRQ_MASK_OFS, 32'h1);
      chk(d[13], "thermal irq");
      sw(0, 1'b0, L);
      wr(`DCI_IRQ_STATUS_OFS, 32'hf);
      chk(!d[13] && !d[5], "irq cleared");
      wr(`DCI_IRQ_MASK_OFS, 32'h0);
      wr(`DCI_CTRL_OFS, 32'h0);
      sw(1, 1'b1, 1);
      sw(1, 1'b0, L);
      chk(!d[3], "bounce ignored");
      sw(1, 1'b1, L);
      chk(d[3] && !d[4], "second set");
      rdx(`DCI_STATUS_OFS, 32'h82);
      wr(`DCI_CTRL_OFS, 32'h40);
      tick(4);
      chk(d[4], "second boost");
      wr(`DCI_CTRL_OFS, 32'h0);
      sw(1, 1'b0, L);
      sw(2, 1'b1, 10);
      sw(2, 1'b0, L);
      rdx(`DCI_IRQ_STATUS_OFS, 32'h0);
      sw(2, 1'b1, 40);
      chk(d[5], "output shut off");
      rdx(`DCI_IRQ_STATUS_OFS, 32'h2);
      sw(2, 1'b0, L);
      wr(`DCI_IRQ_STATUS_OFS, 32'h2);
      chk(!d[5], "shutoff released");
      for (int f = 1; f < 3; f++) begin
         wr(`DCI_CTRL_OFS, 32'(f) << 4);
         sw(2, 1'b1, L);
         chk(d[6] === (f == 1) && d[7] === (f == 2), "stop function");
         sw(2, 1'b0, L);
      end
      wr(`DCI_CTRL_OFS, 32'h3);
      sw(2, 1'b1, 0);
      sw(4, 1'b1, L);
      chk(d[8] && d[9] && !d[10] && !d[5], "converter 3");
      sw(2, 1'b0, 0);
      sw(4, 1'b0, L);
      for (int c = 4; c < 6; c++) begin
         wr(`DCI_CTRL_OFS, 32'(c));
         sw(1, 1'b1, 0);
         sw(4, 1'b1, L);
         chk(d[8] && d[9] && !d[3] && !d[10], "converter 4 5");
         sw(1, 1'b0, 0);
         sw(4, 1'b0, L);
      end
      wr(`DCI_CTRL_OFS, 32'h0);
      sw(4, 1'b1, L);
      chk(d[10], "current accepted");
      sw(4, 1'b0, L);
      chk(!d[10], "current ignored");
      sw(5, 1'b1, L);
      chk(!d[11], "restart default off");
      wr(`DCI_CTRL_OFS, 32'h80);
      tick(4);
      chk(d[11], "restart on");
      @(posedge clk);
      ce <= 1'b0;
      sw(5, 1'b0, L);
      chk(d[11], "frozen by enable");
      @(posedge clk);
      ce <= 1'b1;
      tick(L);
      chk(!d[11], "restart off");
      @(posedge clk);
      trip <= 1'b1;
      sw(3, 1'b1, 30);
      sw(3, 1'b0, 0);
      pulses(0);
      sw(3, 1'b1, 70);
      sw(3, 1'b0, 0);
      pulses(1);
      tally_and_finish;
   end
   initial begin
      tick(20000);
      mismatches++;
      tally_and_finish;
   end
endmodule
